//--- rtl/ulpi_phy_pkg.sv
package ulpi_phy_pkg;

    // operation mode encodings
    localparam logic [1:0] OPERATION_MODE_NORMAL  = 2'h0;
    localparam logic [1:0] OPERATION_MODE_NODRIVE = 2'h1;
    localparam logic [1:0] OPERATION_MODE_RAW     = 2'h2;
    localparam logic [1:0] OPERATION_MODE_NOSYNC  = 2'h3;

    // data values seen with the stop strobe, and the start-of-frame pid
    localparam logic [7:0] STP_EOP_NOSTUFF = 8'hfe;
    localparam logic [7:0] STP_EOP_NONE    = 8'h00;
    localparam logic [7:0] PID_SOF         = 8'ha5;

    // receive command vbus and rx event field encodings
    localparam logic [1:0] VBUS_ENC_VALID   = 2'h3;
    localparam logic [1:0] VBUS_ENC_SESSION = 2'h2;
    localparam logic [1:0] VBUS_ENC_MID     = 2'h1;
    localparam logic [1:0] VBUS_ENC_END     = 2'h0;
    localparam logic [1:0] RX_EVENT_NONE    = 2'h0;

    localparam logic SUSPEND_LOW_RST = 1'b1;
    localparam int   FIFO_DEPTH      = 16;
    localparam int   SYNC_STAGES     = 3;

    typedef enum logic [1:0] {EOP_NORMAL, EOP_NOSTUFF, EOP_NONE, EOP_LONG}
        eop_e;
    typedef enum logic [1:0] {SER_OFF, SER_SIX, SER_THREE} serial_e;

    typedef struct packed {
        logic [7:0] data;
        logic       first;
        logic       last;
        eop_e       eop;
    } tx_word_s;

    typedef struct packed {
        logic [1:0] line_state;
        logic       vbus_valid;
        logic       session_valid;
        logic       session_end;
        logic       id;
    } sense_s;

    localparam int TX_WORD_W = $bits(tx_word_s);
    localparam int SENSE_W   = $bits(sense_s);

endpackage : ulpi_phy_pkg

//--- rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import ulpi_phy_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         sys_clk_i, // clock
    input  wire logic         rst_n_i,   // sync reset, active low
    input  wire logic         ce_i,      // clock enable
    input  wire logic [W-1:0] d_i,       // raw pin levels
    output logic      [W-1:0] q_o        // settled levels
);
    logic [SYNC_STAGES-1:0][W-1:0] stage;
    logic [SYNC_STAGES-1:0][W-1:0] next_stage;
    logic [W-1:0]                  next_q;

    // only the second and third stages are compared
    always_comb begin
        next_stage = {stage[SYNC_STAGES-2:0], d_i};
        next_q     = (stage[1] == stage[2]) ? stage[2] : q_o;
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            stage <= '0;
            q_o   <= '0;
        end else if (ce_i) begin
            stage <= next_stage;
            q_o   <= next_q;
        end
    end
endmodule : pin_sync
`default_nettype wire

//--- rtl/tx_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module tx_fifo
    import ulpi_phy_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 16
) (
    input  wire logic                       sys_clk_i,   // clock
    input  wire logic                       rst_n_i,     // sync reset
    input  wire logic                       ce_i,        // clock enable
    input  wire logic                       in_valid_i,  // write request
    output logic                            in_ready_o,  // not full
    input  wire logic [W-1:0]               in_data_i,   // write word
    output logic                            out_valid_o, // not empty
    input  wire logic                       out_ready_i, // reader takes
    output logic      [W-1:0]               out_data_o,  // head word
    output logic      [$clog2(DEPTH+1)-1:0] level_o      // words held
);
    localparam int AW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH+1);

    logic [DEPTH-1:0][W-1:0] mem;
    logic [DEPTH-1:0][W-1:0] next_mem;
    logic [AW-1:0]           wr_ptr;
    logic [AW-1:0]           rd_ptr;
    logic [AW-1:0]           next_wr;
    logic [AW-1:0]           next_rd;
    logic [LW-1:0]           next_level;
    logic                    push;
    logic                    pop;

    assign in_ready_o  = (level_o != LW'(DEPTH));
    assign out_valid_o = (level_o != '0);
    assign out_data_o  = mem[rd_ptr];

    always_comb begin
        push       = in_valid_i && in_ready_o;
        pop        = out_valid_o && out_ready_i;
        next_mem   = mem;
        next_wr    = wr_ptr;
        next_rd    = rd_ptr;
        next_level = level_o;
        if (push) begin
            next_mem[wr_ptr] = in_data_i;
            next_wr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
        end
        if (pop) begin
            next_rd = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_level = level_o + 1'b1;
        end else if (pop && !push) begin
            next_level = level_o - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mem     <= '0;
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            level_o <= '0;
        end else if (ce_i) begin
            mem     <= next_mem;
            wr_ptr  <= next_wr;
            rd_ptr  <= next_rd;
            level_o <= next_level;
        end
    end
endmodule : tx_fifo
`default_nettype wire

//--- rtl/ulpi_phy_core.sv
`timescale 1ns/10ps
`default_nettype none
module ulpi_phy_core
    import ulpi_phy_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic       sys_clk_i,            // 25 MHz clock
    input  wire logic       rst_n_i,              // sync reset, active low
    input  wire logic       ce_i,                 // clock enable
    input  wire logic       ulpi_stp_i,           // stop strobe from link
    input  wire logic [7:0] ulpi_data_i,          // data bus from link
    output logic      [7:0] ulpi_data_o,          // data bus to link
    output logic            ulpi_data_oe_o,       // phy drives data bus
    output logic            ulpi_dir_o,           // bus direction
    output logic            ulpi_nxt_o,           // byte accepted
    input  wire logic [1:0] operation_mode_i,     // encoding style
    input  wire logic       dplus_pulldown_en_i,  // host pull-down d+
    input  wire logic       dminus_pulldown_en_i, // host pull-down d-
    input  wire logic       id_sense_pullup_en_i, // id sensing on
    input  wire logic       six_wire_serial_en_i, // six-wire serial
    input  wire logic       three_wire_serial_en_i, // three-wire serial
    input  wire logic       suspend_enter_i,      // link writes suspend-low 0
    input  wire logic [1:0] bus_line_state_i,     // raw line state pins
    input  wire logic       vbus_valid_cmp_i,     // comparator pin
    input  wire logic       session_valid_cmp_i,  // comparator pin
    input  wire logic       session_end_cmp_i,    // comparator pin
    input  wire logic       id_pin_i,             // id level pin
    output logic            suspend_low_o,        // 0 while in low power
    output logic            low_power_o,          // low-power state
    output logic            sync_en_o,            // add sync and eop
    output logic            stuff_en_o,           // bit stuffing on
    output logic            nrzi_en_o,            // nrzi encoding on
    output serial_e         serial_mode_o,        // serial mode select
    output tx_word_s        tx_word_o,            // word to serializer
    output logic            tx_valid_o,           // tx_word_o valid
    input  wire logic       tx_ready_i            // serializer takes word
);
    localparam int LW = $clog2(DEPTH+1);

    typedef enum logic [1:0] {BUS_IDLE, BUS_TURN, BUS_DRIVE, BUS_LOWPWR}
        bus_e;
    typedef enum logic [1:0] {TX_IDLE, TX_CMD, TX_DATA} tx_e;

    sense_s        sense_raw;
    sense_s        sense;
    sense_s        reported;
    sense_s        reported_prev;
    sense_s        next_prev;
    logic          sense_chg;
    logic [1:0]    vbus_enc;

    bus_e          bus;
    bus_e          next_bus;
    logic          next_dir;
    logic          next_oe;
    logic [7:0]    next_data;
    logic          rx_pending;
    logic          next_pending;
    logic          next_susp;
    logic          next_lp;
    logic          take_bus;
    logic          dir_prev;
    logic          next_dir_prev;

    tx_e           tx;
    tx_e           next_tx;
    logic          next_nxt;
    logic          first;
    logic          next_first;
    logic          sof_pid;
    logic          next_sof;
    logic          space;
    logic          host_mode;
    logic          push;
    tx_word_s      push_word;
    eop_e          end_eop;

    logic          fifo_out_valid;
    logic          fifo_out_ready;
    logic [TX_WORD_W-1:0] fifo_out;
    logic [LW-1:0] fifo_level;
    logic          fifo_in_ready;

    logic          next_sync;
    logic          next_stuff;
    serial_e       next_serial;
    tx_word_s      next_word;
    logic          next_valid;

    assign sense_raw = '{line_state: bus_line_state_i,
                         vbus_valid: vbus_valid_cmp_i,
                         session_valid: session_valid_cmp_i,
                         session_end: session_end_cmp_i,
                         id: id_pin_i};

    pin_sync #(.W(SENSE_W)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .ce_i      (ce_i),
        .d_i       (sense_raw),
        .q_o       (sense)
    );

    tx_fifo #(.W(TX_WORD_W), .DEPTH(DEPTH)) u_fifo (
        .sys_clk_i   (sys_clk_i),
        .rst_n_i     (rst_n_i),
        .ce_i        (ce_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_in_ready),
        .in_data_i   (push_word),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (fifo_out_ready),
        .out_data_o  (fifo_out),
        .level_o     (fifo_level)
    );

    // id is only reported while its pull-up is on
    always_comb begin
        reported    = sense;
        reported.id = sense.id & id_sense_pullup_en_i;
        sense_chg   = (reported != reported_prev);
        if (reported.vbus_valid) begin
            vbus_enc = VBUS_ENC_VALID;
        end else if (reported.session_valid) begin
            vbus_enc = VBUS_ENC_SESSION;
        end else if (reported.session_end) begin
            vbus_enc = VBUS_ENC_END;
        end else begin
            vbus_enc = VBUS_ENC_MID;
        end
    end

    assign take_bus = rx_pending || suspend_enter_i;

    // bus ownership and turnaround
    always_comb begin
        next_bus     = bus;
        next_dir     = ulpi_dir_o;
        next_oe      = ulpi_data_oe_o;
        next_data    = ulpi_data_o;
        next_pending = rx_pending | sense_chg;
        next_susp    = suspend_low_o;
        next_lp      = low_power_o;
        case (bus)
            BUS_IDLE: begin
                if (take_bus && tx == TX_IDLE) begin
                    next_bus = BUS_TURN;
                    next_dir = 1'b1;
                    if (suspend_enter_i) begin
                        next_susp = 1'b0;
                    end
                end
            end
            BUS_TURN: begin
                next_oe = 1'b1;
                if (!suspend_low_o) begin
                    next_bus  = BUS_LOWPWR;
                    next_lp   = 1'b1;
                    next_data = {6'h00, reported.line_state};
                end else begin
                    next_bus     = BUS_DRIVE;
                    next_pending = sense_chg;
                    next_data    = {1'b0, reported.id, RX_EVENT_NONE,
                                    vbus_enc, reported.line_state};
                end
            end
            BUS_DRIVE: begin
                next_bus  = BUS_IDLE;
                next_dir  = 1'b0;
                next_oe   = 1'b0;
                next_data = 8'h00;
            end
            BUS_LOWPWR: begin
                next_data = {6'h00, reported.line_state};
                if (ulpi_stp_i) begin
                    next_bus  = BUS_IDLE;
                    next_dir  = 1'b0;
                    next_oe   = 1'b0;
                    next_data = 8'h00;
                    next_lp   = 1'b0;
                    next_susp = 1'b1;
                end
            end
            default: begin
                next_bus = BUS_IDLE;
                next_dir = 1'b0;
                next_oe  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            bus            <= BUS_IDLE;
            ulpi_dir_o     <= 1'b0;
            ulpi_data_oe_o <= 1'b0;
            ulpi_data_o    <= 8'h00;
            rx_pending     <= 1'b0;
            dir_prev       <= 1'b0;
            suspend_low_o  <= SUSPEND_LOW_RST;
            low_power_o    <= 1'b0;
            reported_prev  <= '0;
        end else if (ce_i) begin
            bus            <= next_bus;
            ulpi_dir_o     <= next_dir;
            ulpi_data_oe_o <= next_oe;
            ulpi_data_o    <= next_data;
            rx_pending     <= next_pending;
            dir_prev       <= next_dir_prev;
            suspend_low_o  <= next_susp;
            low_power_o    <= next_lp;
            reported_prev  <= next_prev;
        end
    end

    assign next_prev = reported;
    assign next_dir_prev = ulpi_dir_o;
    assign host_mode = dplus_pulldown_en_i && dminus_pulldown_en_i;
    // two spare words cover the nxt lag and the closing word
    assign space     = (fifo_level < LW'(DEPTH-2));

    // end-of-packet style chosen at the stop strobe
    always_comb begin
        end_eop = EOP_NORMAL;
        if (operation_mode_i == OPERATION_MODE_RAW) begin
            end_eop = host_mode ? EOP_NORMAL : EOP_NONE;
        end else if (operation_mode_i == OPERATION_MODE_NOSYNC) begin
            if (ulpi_data_i == STP_EOP_NONE) begin
                end_eop = EOP_NONE;
            end else if (ulpi_data_i == STP_EOP_NOSTUFF) begin
                end_eop = EOP_NOSTUFF;
            end else if (sof_pid) begin
                end_eop = EOP_LONG;
            end
        end
    end

    // transmit intake from the link
    always_comb begin
        next_tx    = tx;
        next_nxt   = 1'b0;
        next_first = first;
        next_sof   = sof_pid;
        push       = 1'b0;
        push_word  = '{data: ulpi_data_i, first: first, last: 1'b0,
                       eop: EOP_NORMAL};
        case (tx)
            TX_IDLE: begin
                // the link drives again only a cycle after dir falls
                if (bus == BUS_IDLE && !take_bus && !ulpi_dir_o &&
                    !dir_prev && ulpi_data_i != 8'h00) begin
                    next_tx  = TX_CMD;
                    next_nxt = space;
                    next_sof = 1'b0;
                end
            end
            TX_CMD: begin
                if (ulpi_stp_i) begin
                    next_tx = TX_IDLE;
                end else begin
                    next_nxt = space;
                    if (ulpi_nxt_o) begin
                        next_tx    = TX_DATA;
                        next_first = 1'b1;
                    end
                end
            end
            TX_DATA: begin
                if (ulpi_stp_i) begin
                    next_tx        = TX_IDLE;
                    push           = 1'b1;
                    push_word.last = 1'b1;
                    push_word.eop  = end_eop;
                end else begin
                    next_nxt = space;
                    if (ulpi_nxt_o) begin
                        push       = 1'b1;
                        next_first = 1'b0;
                        if (first && ulpi_data_i == PID_SOF) begin
                            next_sof = 1'b1;
                        end
                    end
                end
            end
            default: next_tx = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx         <= TX_IDLE;
            ulpi_nxt_o <= 1'b0;
            first      <= 1'b0;
            sof_pid    <= 1'b0;
        end else if (ce_i) begin
            tx         <= next_tx;
            ulpi_nxt_o <= next_nxt;
            first      <= next_first;
            sof_pid    <= next_sof;
        end
    end

    // mode decode and registered output stage toward the serializer
    assign fifo_out_ready = !tx_valid_o || tx_ready_i;

    always_comb begin
        next_sync  = (operation_mode_i != OPERATION_MODE_NOSYNC) &&
                     (operation_mode_i != OPERATION_MODE_RAW);
        next_stuff = (operation_mode_i != OPERATION_MODE_RAW);
        if (six_wire_serial_en_i) begin
            next_serial = SER_SIX;
        end else if (three_wire_serial_en_i) begin
            next_serial = SER_THREE;
        end else begin
            next_serial = SER_OFF;
        end
        next_word  = tx_word_o;
        next_valid = tx_valid_o && !tx_ready_i;
        if (fifo_out_valid && fifo_out_ready) begin
            next_word  = tx_word_s'(fifo_out);
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            sync_en_o     <= 1'b1;
            stuff_en_o    <= 1'b1;
            nrzi_en_o     <= 1'b1;
            serial_mode_o <= SER_OFF;
            tx_word_o     <= '0;
            tx_valid_o    <= 1'b0;
        end else if (ce_i) begin
            sync_en_o     <= next_sync;
            stuff_en_o    <= next_stuff;
            nrzi_en_o     <= next_stuff;
            serial_mode_o <= next_serial;
            tx_word_o     <= next_word;
            tx_valid_o    <= next_valid;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_drive_waits_dir: assert property (
        !ulpi_dir_o ##1 ulpi_dir_o |-> !ulpi_data_oe_o)
        else $error("phy drove data on the first direction cycle");
    a_rxcmd_follows: assert property (
        bus == BUS_TURN && suspend_low_o && ce_i |=>
        (ulpi_data_oe_o && ulpi_dir_o) and (ce_i |=> !ulpi_dir_o))
        else $error("receive command not driven after turnaround");
    a_release_at_once: assert property (
        $fell(ulpi_dir_o) |-> !ulpi_data_oe_o)
        else $error("drivers still on as direction fell");
    a_oe_needs_dir: assert property (
        ulpi_data_oe_o |-> ulpi_dir_o)
        else $error("data driven while direction low");
    a_nosync_mode: assert property (
        operation_mode_i == OPERATION_MODE_NOSYNC && ce_i |=>
        !sync_en_o && stuff_en_o && nrzi_en_o)
        else $error("no-sync mode encoding wrong");
    a_stop_fe_nostuff: assert property (
        tx == TX_DATA && ulpi_stp_i &&
        operation_mode_i == OPERATION_MODE_NOSYNC &&
        ulpi_data_i == STP_EOP_NOSTUFF |->
        push && push_word.last && push_word.eop == EOP_NOSTUFF)
        else $error("FEh stop did not request unstuffed eop");
    a_stop_00_none: assert property (
        tx == TX_DATA && ulpi_stp_i &&
        operation_mode_i == OPERATION_MODE_NOSYNC &&
        ulpi_data_i == STP_EOP_NONE |-> push && push_word.eop == EOP_NONE)
        else $error("00h stop did not suppress eop");
    a_sof_long_eop: assert property (
        tx == TX_DATA && first && ulpi_nxt_o && !ulpi_stp_i &&
        ulpi_data_i == PID_SOF && operation_mode_i == OPERATION_MODE_NOSYNC &&
        ce_i ##1 (!ulpi_stp_i && ce_i) [*2] ##1 ulpi_stp_i &&
        tx == TX_DATA && operation_mode_i == OPERATION_MODE_NOSYNC &&
        ulpi_data_i != STP_EOP_NONE && ulpi_data_i != STP_EOP_NOSTUFF
        |-> push_word.eop == EOP_LONG)
        else $error("start-of-frame packet without long eop");
    a_resume_eop: assert property (
        tx == TX_DATA && ulpi_stp_i && operation_mode_i == OPERATION_MODE_RAW &&
        host_mode |-> push && push_word.eop == EOP_NORMAL)
        else $error("resume end did not append eop");
    a_cmp_reported: assert property (
        ce_i && $changed(reported.vbus_valid) |-> ##[0:1] rx_pending)
        else $error("comparator change not queued for report");
    a_id_reported: assert property (
        ce_i && id_sense_pullup_en_i && $changed(sense.id) &&
        $stable(id_sense_pullup_en_i) |-> ##[0:1] rx_pending)
        else $error("id change not queued for report");
    a_wake_on_stop: assert property (
        bus == BUS_LOWPWR && ulpi_stp_i && ce_i |=>
        suspend_low_o && !low_power_o && !ulpi_dir_o)
        else $error("stop did not leave low power");
    a_serial_select: assert property (
        ce_i && six_wire_serial_en_i |=> serial_mode_o == SER_SIX)
        else $error("six-wire serial mode not selected");

    c_rxcmd: cover property (bus == BUS_DRIVE ##1 !ulpi_dir_o);
    c_packet_end: cover property (push && push_word.last);
    c_sof_long: cover property (push && push_word.eop == EOP_LONG);
    c_low_power_exit: cover property (low_power_o ##1 !low_power_o);
endmodule : ulpi_phy_core
`default_nettype wire

//--- sim/ulpi_link_model.sv
`timescale 1ns/10ps
`default_nettype none
module ulpi_link_model (
    input  wire logic       sys_clk_i,   // clock
    input  wire logic       dir_i,       // phy direction
    input  wire logic       phy_oe_i,    // phy drives bus
    input  wire logic [7:0] phy_data_i,  // phy value
    input  wire logic [7:0] link_data_i, // link value
    output logic      [7:0] bus_o        // resolved wire
);
    logic       dir_q;
    logic [7:0] last;
    always_ff @(posedge sys_clk_i) begin
        dir_q <= dir_i;
        last  <= bus_o;
    end
    // link drops at once on dir, returns one cycle after it falls
    assign bus_o = phy_oe_i ? phy_data_i
                 : (!dir_i && !dir_q) ? link_data_i : ~last;
endmodule : ulpi_link_model
`default_nettype wire

//--- sim/test_ulpi_suspend_resume_turnaround.sv
`timescale 1ns/10ps
`default_nettype none
module test_ulpi_suspend_resume_turnaround;
    import ulpi_phy_pkg::*;
    logic       clk = 1'b0, rst_n = 1'b0, stp = 1'b0, pd = 1'b0, idp = 1'b0;
    logic       six = 1'b0, three = 1'b0, susp = 1'b0, tr = 1'b1;
    logic       vb = 1'b0, sv = 1'b0, se = 1'b0, idpin = 1'b0, got = 1'b0;
    logic       oe, dir, nxt, sl, lp, sy, st, nz, tv;
    logic [1:0] opm = 2'h0, ls = 2'h0;
    logic [7:0] ld = 8'h00, bus, pd8;
    serial_e    ser;
    tx_word_s   tw, lastw;
    int         mismatches = 0, samples_checked = 0, words = 0, cyc = 0;
    ulpi_phy_core u_ulpi_phy_core (.sys_clk_i(clk), .rst_n_i(rst_n),
        .ce_i(1'b1), .ulpi_stp_i(stp), .ulpi_data_i(bus), .ulpi_data_o(pd8),
        .ulpi_data_oe_o(oe), .ulpi_dir_o(dir), .ulpi_nxt_o(nxt),
        .operation_mode_i(opm), .dplus_pulldown_en_i(pd),
        .dminus_pulldown_en_i(pd), .id_sense_pullup_en_i(idp),
        .six_wire_serial_en_i(six), .three_wire_serial_en_i(three),
        .suspend_enter_i(susp), .bus_line_state_i(ls),
        .vbus_valid_cmp_i(vb), .session_valid_cmp_i(sv),
        .session_end_cmp_i(se), .id_pin_i(idpin), .suspend_low_o(sl),
        .low_power_o(lp), .sync_en_o(sy), .stuff_en_o(st), .nrzi_en_o(nz),
        .serial_mode_o(ser), .tx_word_o(tw), .tx_valid_o(tv),
        .tx_ready_i(tr));
    ulpi_link_model u_ulpi_link_model (.sys_clk_i(clk), .dir_i(dir),
        .phy_oe_i(oe), .phy_data_i(pd8), .link_data_i(ld), .bus_o(bus));
    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    always @(negedge clk) if (tv && tr) begin
        words++;
        if (tw.last) begin
            lastw = tw;
            got = 1'b1;
        end
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask : chk
    task automatic wait_for(input bit d);
        int k;
        k = 0;
        @(negedge clk);
        while ((d ? dir : nxt) !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_for
    task automatic chk_rx(input logic [7:0] e);
        wait_for(1'b1);
        chk("oe c0", 8'h00, {7'h00, oe});
        @(negedge clk);
        chk("rxcmd", e, pd8);
        chk("oe c1", 8'h01, {7'h00, oe});
        @(negedge clk);
        chk("release", 8'h00, {6'h00, dir, oe});
    endtask : chk_rx
    task automatic run_pkt(input logic [1:0] m, input logic p,
        input logic [7:0] pid, sd, input eop_e ex, input int n);
        @(posedge clk);
        opm <= m;
        pd <= p;
        ld <= 8'h40;
        got = 1'b0;
        lastw = 'x;
        wait_for(1'b0);
        @(posedge clk);
        ld <= pid;
        for (int i = 0; i <= n; i++) begin
            wait_for(1'b0);
            @(posedge clk);
            ld <= (i == n) ? sd : 8'(i);
            stp <= (i == n);
        end
        @(posedge clk);
        stp <= 1'b0;
        ld <= 8'h00;
        for (int k = 0; k < 300 && !got; k++) @(negedge clk);
        chk("eop", {6'h00, ex}, {6'h00, lastw.eop});
        chk("end data", sd, lastw.data);
        chk("nxt idle", 8'h00, {7'h00, nxt});
    endtask : run_pkt
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset", 8'h5c, {1'b0, sl, lp, sy, st, nz, dir, oe});
        for (int m = 0; m < 4; m++) begin
            @(posedge clk);
            opm <= 2'(m);
            repeat (2) @(negedge clk);
            chk("modes", {5'h00, m < 2, m != 2, m != 2},
                {5'h00, sy, st, nz});
        end
        for (int s = 0; s < 4; s++) begin
            @(posedge clk);
            {six, three} <= 2'(s);
            repeat (2) @(negedge clk);
            chk("serial", s == 0 ? 8'h00 : s == 1 ? 8'h02 : 8'h01,
                {6'h00, ser});
        end
        $display("test modes done");
        @(posedge clk);
        {vb, sv} <= 2'h3;
        chk_rx(8'h0c);
        @(posedge clk);
        ls <= 2'h2;
        chk_rx(8'h0e);
        @(posedge clk);
        {idp, idpin} <= 2'h3;
        chk_rx(8'h4e);
        @(posedge clk);
        {vb, sv, se} <= 3'h1;
        chk_rx(8'h42);
        $display("test reports done");
        @(posedge clk);
        susp <= 1'b1;
        @(posedge clk);
        susp <= 1'b0;
        @(negedge clk);
        chk("suspend", 8'h02, {6'h00, dir, sl});
        @(negedge clk);
        chk("low power", 8'h03, {6'h00, lp, oe});
        chk("ls out", 8'h02, pd8);
        @(posedge clk);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        @(negedge clk);
        chk("wake", 8'h02, {5'h00, dir, sl, lp});
        $display("test suspend done");
        run_pkt(2'h3, 1'b0, 8'h69, STP_EOP_NOSTUFF, EOP_NOSTUFF, 2);
        run_pkt(2'h3, 1'b0, 8'h69, STP_EOP_NONE, EOP_NONE, 2);
        run_pkt(2'h3, 1'b0, PID_SOF, 8'h55, EOP_LONG, 2);
        run_pkt(2'h3, 1'b0, 8'h69, 8'h55, EOP_NORMAL, 2);
        run_pkt(2'h2, 1'b1, 8'h69, 8'h55, EOP_NORMAL, 0);
        run_pkt(2'h2, 1'b0, 8'h69, 8'h55, EOP_NONE, 0);
        @(posedge clk);
        tr <= 1'b0;
        words = 0;
        fork
            begin
                repeat (60) @(posedge clk);
                tr <= 1'b1;
            end
            run_pkt(2'h0, 1'b0, 8'h69, 8'h55, EOP_NORMAL, 18);
        join
        chk("drained", 8'h14, words[7:0]);
        $display("test packets done");
        report_and_stop;
    end
endmodule : test_ulpi_suspend_resume_turnaround
`default_nettype wire
